// ### src/adcrc_pkg.sv
// Shared constants, types and helpers for the converter register control block.
package adcrc_pkg;

  // ==========================================================================
  // Register map, byte addresses on the bus.
  localparam logic [7:0] ADDR_RESULT_LOW  = 8'h00;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'h04;
  localparam logic [7:0] ADDR_CTRL_A      = 8'h08;
  localparam logic [7:0] ADDR_CTRL_B      = 8'h0C;
  localparam logic [7:0] ADDR_PIN_ENABLE  = 8'h10;

  // ==========================================================================
  // Field positions, masks and reset values.
  localparam int START_BIT  = 7;
  localparam int BUSY_BIT   = 6;
  localparam int ENABLE_BIT = 5;
  localparam int FORMAT_BIT = 4;
  localparam logic [7:0] CTRL_A_RESET    = 8'h00;
  localparam logic [7:0] CTRL_B_RESET    = 8'h00;
  localparam logic [7:0] CTRL_B_MASK     = 8'hE7;
  localparam logic [7:0] PIN_ENABLE_MASK = 8'h0F;
  localparam logic [7:0] PIN_RESET       = 8'h00;
  localparam logic [11:0] RESULT_RESET   = 12'h000;

  // ==========================================================================
  // Conversion length in conversion clock ticks and source codes.
  localparam logic [4:0] CONV_TICKS       = 5'h0E;
  localparam logic [2:0] SRC_PROTECTION   = 3'h1;
  localparam logic [2:0] SRC_GROUND_FIRST = 3'h2;
  localparam logic [2:0] SRC_GROUND_LAST  = 3'h4;
  localparam logic [3:0] CHANNEL_COUNT    = 4'h4;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_CONVERT = 2'b01,
    ST_LOAD    = 2'b11
  } adcrc_state_e;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } adcrc_wb_req_s;

  typedef struct packed {
    logic [3:0] channelConnect;
    logic       protectionConnect;
    logic       groundConnect;
  } adcrc_route_s;

  // High byte of the result for the chosen justification.
  function automatic logic [7:0] formatHigh(input logic [11:0] raw, input logic rightJust);
    formatHigh = rightJust ? {4'h0, raw[11:8]} : raw[11:4]; // RQ5 RQ6 RQ7
  endfunction : formatHigh

  // Low byte of the result for the chosen justification.
  function automatic logic [7:0] formatLow(input logic [11:0] raw, input logic rightJust);
    formatLow = rightJust ? raw[7:0] : {raw[3:0], 4'h0}; // RQ5 RQ6 RQ7
  endfunction : formatLow

  // Analog switch settings for a source code and a channel code.
  function automatic adcrc_route_s routeFor(input logic [2:0] src, input logic [3:0] chan);
    adcrc_route_s r;
    r = '0;
    if (src == SRC_PROTECTION)
    begin
      r.protectionConnect = 1'b1; // RQ9
    end
    else if (src >= SRC_GROUND_FIRST && src <= SRC_GROUND_LAST)
    begin
      r.groundConnect = 1'b1; // RQ9
    end
    if (chan < CHANNEL_COUNT)
    begin
      r.channelConnect = 4'h1 << chan[1:0]; // RQ8
    end
    routeFor = r;
  endfunction : routeFor

endpackage : adcrc_pkg

// ### src/adcrc_clk_div.sv
// Conversion clock divider producing one tick every two to the code system cycles.
module adcrc_clk_div
  import adcrc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [2:0] divCode,
  output logic            tick
);

  logic [6:0] count;
  logic [6:0] limit;

  assign limit = 7'((8'h01 << divCode) - 8'h01);

  always_ff @(posedge clk)
  begin
    if (rst || !run)
    begin
      count <= 7'h00;
      tick  <= 1'b0;
    end
    else if (count >= limit)
    begin
      count <= 7'h00;
      tick  <= 1'b1; // RQ11
    end
    else
    begin
      count <= count + 7'h01;
      tick  <= 1'b0;
    end
  end

endmodule : adcrc_clk_div

// ### src/adcrc_result_regs.sv
// Result byte pair, loaded together in one justified update.
module adcrc_result_regs
  import adcrc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        load,
  input  wire logic        rightJust,
  input  wire logic [11:0] raw,
  output logic [7:0]       highByte,
  output logic [7:0]       lowByte
);

  // Both bytes change on the same edge so a reader never sees a mixed pair.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      highByte <= formatHigh(RESULT_RESET, 1'b0);
      lowByte  <= formatLow(RESULT_RESET, 1'b0);
    end
    else if (load)
    begin
      highByte <= formatHigh(raw, rightJust); // RQ18
      lowByte  <= formatLow(raw, rightJust); // RQ18
    end
  end

endmodule : adcrc_result_regs

// ### src/adcrc_top.sv
// Register control for the 12-bit converter, reached over a classic Wishbone slave.
// ============================================================================
// Function
// RQ1 - A start bit written high then low launches exactly one conversion.
// RQ2 - Busy flag sets on launch and clears when the conversion completes.
// RQ3 - Busy flag is read-only; writes to its bit are ignored.
// RQ4 - Enable low powers the converter down; result bytes keep their contents.
// RQ5 - Format zero: high byte holds bits 11..4, low upper nibble bits 3..0.
// RQ6 - Format one: high lower nibble holds bits 11..8, low byte bits 7..0.
// RQ7 - Result positions without a result bit read as zero.
// RQ8 - Channel codes 0..3 connect inputs 0..3; codes 4..15 connect nothing.
// RQ9 - Source 001 picks protection output, 010..100 ground, others external channel.
// RQ10 - Software parks channel field at 4..15 before picking internal or ground.
// RQ11 - Conversion clock is system clock divided by two to the divider code.
// RQ12 - Each pin enable bit turns its port pin into an analog input.
// RQ13 - An analog input pin has its pull-high resistor disconnected.
// RQ14 - Bits 4 and 3 of control register b read zero and ignore writes.
// RQ15 - Bits 7..4 of the pin enable register read zero and ignore writes.
// RQ16 - Completion raises the converter interrupt request.
// RQ17 - Software waits a settling delay after enabling before any start.
// RQ18 - Both result bytes update together as the busy flag clears.
// RQ19 - A start sequence during a busy conversion is ignored.
//
// Decided for this implementation: the register offsets and the Wishbone slave port.
module adcrc_top
  import adcrc_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire adcrc_wb_req_s wbReq,
  input  wire logic [11:0]   convResult,
  output logic               wbAck,
  output logic [31:0]        wbDatRead,
  output logic               converterPowerOn,
  output logic               convClockTick,
  output logic               sampleStart,
  output logic               conversionBusy,
  output logic               completeIrq,
  output adcrc_route_s       inputRoute,
  output logic [3:0]         analogPinMode,
  output logic [3:0]         pullHighDisable
);

  // ==========================================================================
  // Declarations.
  logic             access;
  logic             writeNow;
  logic [7:0]       wrByte;
  logic [7:0]       readMux;
  logic             startBit;
  logic             enableBit;
  logic             formatBit;
  logic [3:0]       channelSelect;
  logic [2:0]       sourceSelect;
  logic [2:0]       clockDivider;
  logic [3:0]       pinEnable;
  logic             busy;
  logic             launch;
  logic             ctrlAWrite;
  logic             divTick;
  logic [4:0]       tickCount;
  logic [7:0]       resultHigh;
  logic [7:0]       resultLow;
  adcrc_state_e     state;
  adcrc_state_e     next_state;

  // ==========================================================================
  // Wishbone slave.
  // The ack is registered, so every access takes two edges: ack rises at the
  // first and the write lands at the second, where the master samples ack.
  assign access   = wbReq.cyc && wbReq.stb;
  assign writeNow = access && wbReq.we && wbAck && wbReq.sel[0];
  assign wrByte   = wbReq.dat[7:0];

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wbAck <= 1'b0;
    end
    else
    begin
      wbAck <= access && !wbAck;
    end
  end

  always_comb
  begin
    readMux = 8'h00;
    case (wbReq.adr)
      ADDR_RESULT_LOW:
      begin
        readMux = resultLow;
      end
      ADDR_RESULT_HIGH:
      begin
        readMux = resultHigh;
      end
      ADDR_CTRL_A:
      begin
        readMux = {startBit, busy, enableBit, formatBit, channelSelect};
      end
      ADDR_CTRL_B:
      begin
        readMux = {sourceSelect, 2'b00, clockDivider}; // RQ14
      end
      ADDR_PIN_ENABLE:
      begin
        readMux = {4'h0, pinEnable}; // RQ15
      end
      default:
      begin
        readMux = 8'h00;
      end
    endcase
  end

  // Read data is captured with ack and held at zero otherwise.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wbDatRead <= 32'h0000_0000;
    end
    else if (access && !wbAck && !wbReq.we)
    begin
      wbDatRead <= {24'h00_0000, readMux};
    end
    else
    begin
      wbDatRead <= 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Control register a.
  assign ctrlAWrite = writeNow && (wbReq.adr == ADDR_CTRL_A);

  // The busy position of the written byte is simply dropped here.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      startBit      <= CTRL_A_RESET[START_BIT];
      enableBit     <= CTRL_A_RESET[ENABLE_BIT];
      formatBit     <= CTRL_A_RESET[FORMAT_BIT];
      channelSelect <= CTRL_A_RESET[3:0];
    end
    else if (ctrlAWrite)
    begin
      startBit      <= wrByte[START_BIT];
      enableBit     <= wrByte[ENABLE_BIT];
      formatBit     <= wrByte[FORMAT_BIT];
      channelSelect <= wrByte[3:0]; // RQ3
    end
  end

  // A launch is the write that brings a set start bit back to zero. Software
  // owes the power-up settling delay after enabling; nothing here enforces it.
  assign launch = ctrlAWrite && startBit && !wrByte[START_BIT]
                  && enableBit && wrByte[ENABLE_BIT]
                  && (state == ST_IDLE) && !busy; // RQ1 RQ19 RQ17

  // ==========================================================================
  // Control register b and pin enable register.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sourceSelect <= CTRL_B_RESET[7:5];
      clockDivider <= CTRL_B_RESET[2:0];
    end
    else if (writeNow && wbReq.adr == ADDR_CTRL_B)
    begin
      sourceSelect <= wrByte[7:5];
      clockDivider <= wrByte[2:0] & CTRL_B_MASK[2:0]; // RQ14
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pinEnable <= PIN_RESET[3:0];
    end
    else if (writeNow && wbReq.adr == ADDR_PIN_ENABLE)
    begin
      pinEnable <= wrByte[3:0] & PIN_ENABLE_MASK[3:0]; // RQ15
    end
  end

  // ==========================================================================
  // Conversion sequencer.
  adcrc_clk_div u_clk_div (
    .clk     (clk),
    .rst     (rst),
    .run     (state == ST_CONVERT),
    .divCode (clockDivider),
    .tick    (divTick)
  );

  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (launch)
        begin
          next_state = ST_CONVERT;
        end
      end
      ST_CONVERT:
      begin
        if (!enableBit)
        begin
          next_state = ST_IDLE; // RQ4
        end
        else if (divTick && tickCount == CONV_TICKS - 5'h01)
        begin
          next_state = ST_LOAD;
        end
      end
      ST_LOAD:
      begin
        next_state = ST_IDLE;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst || state != ST_CONVERT)
    begin
      tickCount <= 5'h00;
    end
    else if (divTick)
    begin
      tickCount <= tickCount + 5'h01;
    end
  end

  // Busy sets with the launch and clears on the edge that loads the result.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      busy <= 1'b0;
    end
    else if (launch)
    begin
      busy <= 1'b1; // RQ2
    end
    else if (state == ST_LOAD || (state == ST_CONVERT && !enableBit))
    begin
      busy <= 1'b0; // RQ2
    end
  end

  // The load also requires the enable bit, so an aborted conversion never loads and results hold.
  adcrc_result_regs u_result_regs (
    .clk       (clk),
    .rst       (rst),
    .load      (state == ST_LOAD && enableBit),
    .rightJust (formatBit),
    .raw       (convResult),
    .highByte  (resultHigh),
    .lowByte   (resultLow)
  ); // RQ4 RQ18

  // ==========================================================================
  // Registered outputs.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      completeIrq <= 1'b0;
      sampleStart <= 1'b0;
    end
    else
    begin
      completeIrq <= (state == ST_LOAD) && enableBit; // RQ16
      sampleStart <= launch;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      converterPowerOn <= 1'b0;
      convClockTick    <= 1'b0;
      conversionBusy   <= 1'b0;
    end
    else
    begin
      converterPowerOn <= enableBit; // RQ4
      convClockTick    <= divTick && (state == ST_CONVERT); // RQ11
      conversionBusy   <= busy;
    end
  end

  // Routing follows the fields directly; parking the channel code before an
  // internal source is chosen is left to software.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      inputRoute <= '0;
    end
    else
    begin
      inputRoute <= routeFor(sourceSelect, channelSelect); // RQ8 RQ9 RQ10
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      analogPinMode   <= 4'h0;
      pullHighDisable <= 4'h0;
    end
    else
    begin
      analogPinMode   <= pinEnable; // RQ12
      pullHighDisable <= pinEnable; // RQ13
    end
  end

endmodule : adcrc_top

// ### testbench/adcrc_checker.sv
// Port-level assertions for the converter register control block.
module adcrc_checker
  import adcrc_pkg::*;
(
  input wire logic          clk,
  input wire logic          rst,
  input wire adcrc_wb_req_s wbReq,
  input wire logic          wbAck,
  input wire logic [31:0]   wbDatRead,
  input wire logic          converterPowerOn,
  input wire logic          sampleStart,
  input wire logic          conversionBusy,
  input wire logic          completeIrq,
  input wire adcrc_route_s  inputRoute,
  input wire logic [3:0]    analogPinMode,
  input wire logic [3:0]    pullHighDisable
);
  // ==========
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic rdB;
  logic rdP;
  assign rdB = wbAck && !wbReq.we && wbReq.adr == ADDR_CTRL_B;
  assign rdP = wbAck && !wbReq.we && wbReq.adr == ADDR_PIN_ENABLE;
  ack_after_req_a: assert property (wbReq.cyc && wbReq.stb && !wbAck |=> wbAck)
    else $error("ack missing after request");
  ack_one_cycle_a: assert property (wbAck |=> !wbAck)
    else $error("ack held too long");
  read_idle_zero_a: assert property (!wbAck |-> wbDatRead == 32'h0000_0000)
    else $error("read data outside ack");
  ctrlb_gap_zero_a: assert property (rdB |-> wbDatRead[4:3] == 2'b00)
    else $error("control b gap bits not zero");
  pin_top_zero_a: assert property (rdP |-> wbDatRead[7:4] == 4'h0)
    else $error("pin enable upper bits not zero");
  pull_follows_pin_a: assert property (pullHighDisable == analogPinMode)
    else $error("pull-high not removed on analog pin");
  chan_onehot_a: assert property ($onehot0(inputRoute.channelConnect))
    else $error("several channels connected");
  src_exclusive_a: assert property (!(inputRoute.protectionConnect && inputRoute.groundConnect))
    else $error("protection and ground both connected");
  start_sets_busy_a: assert property (sampleStart |-> ##[0:1] conversionBusy)
    else $error("busy not set on launch");
  irq_after_busy_a: assert property (completeIrq |-> $past(conversionBusy))
    else $error("completion without conversion");
  off_no_launch_a: assert property (!converterPowerOn [*3] |-> !sampleStart && !completeIrq)
    else $error("activity while powered down");
  cover property (completeIrq);
  cover property (sampleStart);
  cover property (inputRoute.protectionConnect);
endmodule : adcrc_checker

bind adcrc_top adcrc_checker u_chk (
  .clk(clk), .rst(rst), .wbReq(wbReq), .wbAck(wbAck), .wbDatRead(wbDatRead),
  .converterPowerOn(converterPowerOn), .sampleStart(sampleStart),
  .conversionBusy(conversionBusy), .completeIrq(completeIrq), .inputRoute(inputRoute),
  .analogPinMode(analogPinMode), .pullHighDisable(pullHighDisable)
);

// ### testbench/adcrc_analog_model.sv
// Behavioural analog front end: four pins, protection output and ground.
module adcrc_analog_model
  import adcrc_pkg::*;
(
  input  wire logic         clk,
  input  wire adcrc_route_s inputRoute,
  input  wire logic [47:0]  pinLevels,
  input  wire logic [11:0]  protLevel,
  output logic [11:0]       convResult
);
  logic [11:0] floatPat = 12'h05A5;
  always @(posedge clk)
  begin
    floatPat <= ~floatPat;
  end
  // An open input has no level, so it shows a pattern that changes each cycle.
  always_comb
  begin
    convResult = floatPat;
    for (int i = 0; i < 4; i++)
      if (inputRoute.channelConnect[i]) convResult = pinLevels[12*i +: 12];
    if (inputRoute.protectionConnect) convResult = protLevel;
    if (inputRoute.groundConnect) convResult = 12'h0000;
  end
endmodule : adcrc_analog_model

// ### testbench/adcrc_top_tb_top.sv
// Self-checking bench for the converter register control block.
module adcrc_top_tb_top;
  import adcrc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  adcrc_wb_req_s wbReq = '0;
  logic [11:0] convResult, protLevel = '0;
  logic [47:0] pinLevels = '0;
  logic wbAck, converterPowerOn, convClockTick, sampleStart, conversionBusy, completeIrq;
  logic [31:0] wbDatRead;
  adcrc_route_s inputRoute;
  logic [3:0] analogPinMode, pullHighDisable, c;
  logic [7:0] r, v, hi, lo;
  logic [11:0] raw;
  logic [2:0] s;
  int err_total = 0, n_tests = 0, cycles = 0, tickCnt = 0, irqCnt = 0, tickGap = 0, lastTick = 0;

  adcrc_top DUT (.clk(clk), .rst(rst), .wbReq(wbReq), .convResult(convResult),
    .wbAck(wbAck), .wbDatRead(wbDatRead), .converterPowerOn(converterPowerOn),
    .convClockTick(convClockTick), .sampleStart(sampleStart),
    .conversionBusy(conversionBusy), .completeIrq(completeIrq), .inputRoute(inputRoute),
    .analogPinMode(analogPinMode), .pullHighDisable(pullHighDisable));
  adcrc_analog_model u_ana (.clk(clk), .inputRoute(inputRoute), .pinLevels(pinLevels),
    .protLevel(protLevel), .convResult(convResult));

  initial
  begin
    forever #25 clk = ~clk;
  end

  // ======================
  // Monitors and timeout
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (convClockTick)
    begin
      tickCnt <= tickCnt + 1;
      tickGap <= cycles - lastTick;
      lastTick <= cycles;
    end
    if (completeIrq) irqCnt <= irqCnt + 1;
    if (cycles == 30000)
    begin
      err_total++;
      wrap_up();
    end
  end

  // ======================
  // Tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // The request stays put until ack is seen, then drops for a cycle.
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: {24'h00_0000, d}};
    do @(posedge clk); while (wbAck !== 1'b1);
    q = wbDatRead[7:0];
    wbReq <= '0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  function automatic logic [31:0] expRoute(input logic [2:0] s, input logic [3:0] c);
    adcrc_route_s e;
    e = '0;
    e.protectionConnect = (s == 3'h1);
    e.groundConnect = (s >= 3'h2 && s <= 3'h4);
    if (c < 4'h4) e.channelConnect = 4'h1 << c;
    expRoute = 32'(e);
  endfunction : expRoute

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  // ======================
  // Main sequence
  initial
  begin
    void'($urandom(32'h9da6));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 6; a++)
    begin
      wb(1'b0, 8'(a * 4), 8'h00, r);
      check("reset or unmapped read", r, 32'h0000_0000);
    end
    check("reset route", 32'(inputRoute), 32'h0000_0004);
    for (int k = 0; k < 8; k++)
    begin
      s = 3'(k);
      // Internal and ground sources get a parked channel code first.
      c = (s >= 3'h1 && s <= 3'h4) ? 4'(4 + $urandom_range(11)) : 4'($urandom_range(3));
      pinLevels <= {$urandom, 16'($urandom)};
      protLevel <= 12'($urandom);
      wr(ADDR_CTRL_A, {3'b011, s[0], c});
      wr(ADDR_CTRL_B, {s, 2'b11, s});
      repeat (2) @(negedge clk);
      check("route", 32'(inputRoute), expRoute(s, c));
      wb(1'b0, ADDR_CTRL_B, 8'h00, r);
      check("ctrl b", r, {s, 2'b00, s});
      wb(1'b0, ADDR_CTRL_A, 8'h00, r);
      check("ctrl a idle", r, {3'b001, s[0], c});
      raw = (s == 3'h1) ? protLevel : (s >= 3'h2 && s <= 3'h4) ? 12'h000 : pinLevels[12*c +: 12];
      tickCnt = 0;
      irqCnt = 0;
      wr(ADDR_CTRL_A, {3'b101, s[0], c});
      wr(ADDR_CTRL_A, {3'b001, s[0], c});
      wb(1'b0, ADDR_CTRL_A, 8'h00, r);
      check("busy set", r[BUSY_BIT], 32'h0000_0001);
      if (k == 3)
      begin
        wr(ADDR_CTRL_A, {3'b101, s[0], c});
        wr(ADDR_CTRL_A, {3'b001, s[0], c});
      end
      do wb(1'b0, ADDR_CTRL_A, 8'h00, r); while (r[BUSY_BIT] !== 1'b0);
      repeat (2) @(negedge clk);
      check("ticks", tickCnt, 32'(CONV_TICKS));
      check("tick spacing", tickGap, 32'h1 << s);
      check("irq count", irqCnt, 32'h0000_0001);
      hi = s[0] ? {4'h0, raw[11:8]} : raw[11:4];
      lo = s[0] ? raw[7:0] : {raw[3:0], 4'h0};
      wb(1'b0, ADDR_RESULT_HIGH, 8'h00, r);
      check("result high", r, hi);
      wb(1'b0, ADDR_RESULT_LOW, 8'h00, r);
      check("result low", r, lo);
    end
    pinLevels <= ~pinLevels;
    irqCnt = 0;
    wr(ADDR_CTRL_A, {3'b101, s[0], c});
    wr(ADDR_CTRL_A, {3'b001, s[0], c});
    wr(ADDR_CTRL_A, 8'h00);
    wr(ADDR_CTRL_A, 8'h80);
    wr(ADDR_CTRL_A, 8'h00);
    repeat (40) @(negedge clk);
    check("power off", converterPowerOn, 32'h0000_0000);
    check("abort irq", irqCnt, 32'h0000_0000);
    wb(1'b0, ADDR_CTRL_A, 8'h00, r);
    check("no launch when off", r, 32'h0000_0000);
    wb(1'b0, ADDR_RESULT_HIGH, 8'h00, r);
    check("kept high", r, hi);
    wb(1'b0, ADDR_RESULT_LOW, 8'h00, r);
    check("kept low", r, lo);
    for (int k = 0; k < 4; k++)
    begin
      v = 8'($urandom);
      wr(ADDR_PIN_ENABLE, v);
      wb(1'b0, ADDR_PIN_ENABLE, 8'h00, r);
      check("pin enable", r, {4'h0, v[3:0]});
      check("pin mode", analogPinMode, v[3:0]);
      check("pull removed", pullHighDisable, v[3:0]);
    end
    wrap_up();
  end
endmodule : adcrc_top_tb_top
